/* File: logic/dpot_pkg.sv */
// Purpose: shared constants and types of the serial pot register slave
// Assumes: mclk at 40 MHz; bus lines sampled by mclk
// Notes:   register indices are the bus address byte values
package dpot_pkg;

  localparam int unsigned MCLK_HZ         = 40_000_000;
  localparam int unsigned NV_WRITE_MAX_MS = 20;
  localparam int unsigned NV_WRITE_CYC    = (MCLK_HZ / 1000) * NV_WRITE_MAX_MS;
  localparam int unsigned POWERUP_US      = 10;
  localparam int unsigned POWERUP_CYC     = (MCLK_HZ / 1_000_000) * POWERUP_US;

  localparam logic [6:0] DEV_ID7         = 7'h28;
  localparam logic [7:0] ADDR_WIPER      = 8'h00;
  localparam logic [7:0] ADDR_REVISION   = 8'h01;
  localparam logic [7:0] ADDR_USER_FIRST = 8'h02;
  localparam logic [7:0] ADDR_USER_LAST  = 8'h06;
  localparam logic [7:0] ADDR_RESERVED   = 8'h07;
  localparam logic [7:0] ADDR_ACCESS     = 8'h08;
  localparam int unsigned VOL_BIT        = 7;
  localparam int unsigned USER_BYTES     = 5;

  localparam logic [7:0] WIPER_POWERUP  = 8'h80;
  localparam logic [7:0] INIT_SHIPPED   = 8'h80;
  localparam logic [7:0] ACCESS_RESET   = 8'h00;
  localparam logic [7:0] USER_SHIPPED   = 8'h00;

  typedef enum logic [2:0] {
    DPOT_POWERUP = 3'b000,
    DPOT_IDLE    = 3'b001,
    DPOT_RX      = 3'b010,
    DPOT_ACK     = 3'b011,
    DPOT_TX      = 3'b100,
    DPOT_TXACK   = 3'b101,
    DPOT_NVWRITE = 3'b110
  } dpot_state_e;

  typedef enum logic [1:0] {
    DPOT_PH_ID   = 2'b00,
    DPOT_PH_ADDR = 2'b01,
    DPOT_PH_DATA = 2'b10
  } dpot_phase_e;

  // sampled bus lines
  typedef struct packed {
    logic scl;
    logic sda;
  } dpot_bus_s;

  typedef struct packed {
    dpot_state_e          st;
    dpot_phase_e          ph;
    logic [3:0]           bit_n;
    logic [7:0]           shift;
    logic [7:0]           addr;
    logic                 rd_mode;
    logic                 ack_go;
    logic                 nv_pend;
    logic [7:0]           nv_byte;
    logic [7:0]           nv_addr;
    logic [31:0]          cnt;
    logic                 sda_oe;
    logic [7:0]           wiper;
    logic [7:0]           init_nv;
    logic [7:0]           access;
    logic [USER_BYTES*8-1:0] user_nv;
    dpot_bus_s            s1;
    dpot_bus_s            s2;
    dpot_bus_s            s3;
    logic                 wl1;
    logic                 wl2;
  } dpot_state_s;

endpackage

/* File: logic/dpot_slave.sv */
// Purpose: two-wire slave front end and register set of a 256-tap pot
// Assumes: bus lines and write lock come from outside and are synchronised here
// Notes:   nonvolatile cells are modelled as flip-flops with a timed write

////////////////////////////////////////////////////////////////////////////////
// How it works
// R1: wiper tap output follows wiper register
// R2: tap code equals wiper value, monotonic
// R3: hold 80h at power-up, then recall
// R4: stored initial value ships as 80h
// R5: decode addresses 0,1,2-6,7,8
// R6: volatile_select picks wiper versus nonvolatile bytes
// R7: volatile_select resets 0, low bits zero
// R8: initial value write also updates wiper
// R9: revision byte read-only at address 1
// R10: slave only; master clocks everything
// R11: bytes travel most significant bit first
// R12: sda change with scl high: start/stop
// R13: ignore bus until a start
// R14: starts ignored at power-up, during nonvolatile write
// R15: stop returns standby or launches nonvolatile write
// R16: release after 8 bits; receiver acks ninth
// R17: ack id, address and write data
// R18: master acks each read byte
// R19: id upper bits 0101000, lsb read
// R20: data pin undriven at power-up
// R21: sample on rising, drive after falling
// R22: write lock discards write data
// R23: wiper/access load at last data bit
// R24: locked write data unacked, back to standby
// R25: nonvolatile write within 20 ms, bus deaf
// R26: read needs address write then restart
// R27: reserved address reads zero, writes ignored
module dpot_slave #(
  parameter int unsigned NV_WRITE_CYCLES = dpot_pkg::NV_WRITE_CYC,
  parameter int unsigned POWERUP_CYCLES  = dpot_pkg::POWERUP_CYC,
  parameter logic [7:0]  REVISION        = 8'h5a  // arbitrary value
) (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       write_lock_n,
  output logic [7:0]      wiper_tap,
  output logic            nv_busy
);

  if (NV_WRITE_CYCLES < 1 || POWERUP_CYCLES < 1) begin : g_bad_counts
    $error("dpot_slave: cycle counts must be at least one");
  end

  dpot_pkg::dpot_state_s q;
  dpot_pkg::dpot_state_s d;

  function automatic logic [7:0] read_byte(input logic [7:0] a, input dpot_pkg::dpot_state_s s);
    logic [7:0] r;
    r = 8'h00;
    if (a == dpot_pkg::ADDR_ACCESS) begin
      r = {s.access[dpot_pkg::VOL_BIT], 7'h00};  // see R7
    end else if (s.access[dpot_pkg::VOL_BIT]) begin
      if (a == dpot_pkg::ADDR_WIPER) r = s.wiper;  // see R6
    end else if (a == dpot_pkg::ADDR_WIPER) begin
      r = s.init_nv;
    end else if (a == dpot_pkg::ADDR_REVISION) begin
      r = REVISION;  // see R9
    end else if (a >= dpot_pkg::ADDR_USER_FIRST && a <= dpot_pkg::ADDR_USER_LAST) begin
      r = s.user_nv[8*(a - dpot_pkg::ADDR_USER_FIRST) +: 8];  // see R5
    end
    return r;  // see R27
  endfunction

  logic       scl_rise;
  logic       scl_fall;
  logic       start_ev;
  logic       stop_ev;
  logic [7:0] rd_byte;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    // edges seen only on second and third stage
    scl_rise = q.s2.scl & ~q.s3.scl;  // see R21 R10
    scl_fall = ~q.s2.scl & q.s3.scl;
    start_ev = q.s2.scl & q.s3.scl & q.s3.sda & ~q.s2.sda;  // see R12
    stop_ev  = q.s2.scl & q.s3.scl & ~q.s3.sda & q.s2.sda;
    rd_byte  = read_byte(q.addr, q);

    d = q;
    d.s1  = '{scl: scl_in, sda: sda_in};
    d.s2  = q.s1;
    d.s3  = q.s2;
    d.wl1 = write_lock_n;
    d.wl2 = q.wl1;

    unique case (q.st)
      dpot_pkg::DPOT_POWERUP: begin
        d.sda_oe = 1'b0;  // see R20
        if (q.cnt >= 32'(POWERUP_CYCLES - 1)) begin
          d.wiper = q.init_nv;  // see R3
          d.st    = dpot_pkg::DPOT_IDLE;
          d.cnt   = '0;
        end else begin
          d.cnt = q.cnt + 32'd1;
        end
      end
      dpot_pkg::DPOT_NVWRITE: begin
        d.sda_oe = 1'b0;  // see R25
        if (q.cnt >= 32'(NV_WRITE_CYCLES - 1)) begin
          if (q.nv_addr == dpot_pkg::ADDR_WIPER) begin
            d.init_nv = q.nv_byte;
          end else begin
            d.user_nv[8*(q.nv_addr - dpot_pkg::ADDR_USER_FIRST) +: 8] = q.nv_byte;
          end
          d.st  = dpot_pkg::DPOT_IDLE;  // see R15
          d.cnt = '0;
        end else begin
          d.cnt = q.cnt + 32'd1;
        end
      end
      default: begin
        if (start_ev) begin
          // repeated start keeps address and pending state
          d.st     = dpot_pkg::DPOT_RX;  // see R13
          d.ph     = dpot_pkg::DPOT_PH_ID;
          d.bit_n  = 4'd0;
          d.sda_oe = 1'b0;
        end else if (stop_ev) begin
          d.sda_oe = 1'b0;
          if (q.nv_pend) begin
            d.st      = dpot_pkg::DPOT_NVWRITE;  // see R15
            d.nv_pend = 1'b0;
            d.cnt     = '0;
          end else begin
            d.st = dpot_pkg::DPOT_IDLE;
          end
        end else begin
          unique case (q.st)
            dpot_pkg::DPOT_IDLE: d.sda_oe = 1'b0;
            dpot_pkg::DPOT_RX: begin
              if (scl_rise) begin
                d.shift = {q.shift[6:0], q.s2.sda};  // see R11
                d.bit_n = q.bit_n + 4'd1;
              end else if (scl_fall && q.bit_n == 4'd8) begin
                d.bit_n  = 4'd0;
                d.ack_go = 1'b1;
                unique case (q.ph)
                  dpot_pkg::DPOT_PH_ID: begin
                    d.rd_mode = q.shift[0];  // see R19
                    if (q.shift[7:1] != dpot_pkg::DEV_ID7) begin
                      d.ack_go = 1'b0;  // see R19
                    end else if (q.shift[0]) begin
                      d.ph = dpot_pkg::DPOT_PH_DATA;
                      d.nv_pend = 1'b0;
                    end else begin
                      d.ph = dpot_pkg::DPOT_PH_ADDR;
                    end
                  end
                  dpot_pkg::DPOT_PH_ADDR: begin
                    d.addr = q.shift;
                    d.ph   = dpot_pkg::DPOT_PH_DATA;
                  end
                  default: begin
                    if (!q.wl2) begin
                      d.ack_go = 1'b0;  // see R22 R24
                    end else if (q.addr == dpot_pkg::ADDR_ACCESS) begin
                      d.access = {q.shift[dpot_pkg::VOL_BIT], 7'h00};  // see R23
                    end else if (q.access[dpot_pkg::VOL_BIT]) begin
                      if (q.addr == dpot_pkg::ADDR_WIPER) d.wiper = q.shift;  // see R6 R23
                    end else if (q.addr == dpot_pkg::ADDR_WIPER ||
                                 (q.addr >= dpot_pkg::ADDR_USER_FIRST &&
                                  q.addr <= dpot_pkg::ADDR_USER_LAST)) begin
                      if (q.addr == dpot_pkg::ADDR_WIPER) d.wiper = q.shift;  // see R8
                      d.nv_pend = 1'b1;
                      d.nv_byte = q.shift;
                      d.nv_addr = q.addr;
                    end
                  end
                endcase
                if (d.ack_go) begin
                  d.st     = dpot_pkg::DPOT_ACK;
                  d.sda_oe = 1'b1;  // see R16 R17
                end else begin
                  d.st = dpot_pkg::DPOT_IDLE;  // see R24
                end
              end
            end
            dpot_pkg::DPOT_ACK: begin
              if (scl_fall) begin
                d.sda_oe = 1'b0;
                if (q.rd_mode) begin
                  // read id acked: first data bit goes out now
                  d.st     = dpot_pkg::DPOT_TX;
                  d.shift  = rd_byte;
                  d.sda_oe = ~rd_byte[7];  // see R21
                  d.bit_n  = 4'd1;
                end else begin
                  d.st = dpot_pkg::DPOT_RX;
                end
              end
            end
            dpot_pkg::DPOT_TX: begin
              if (scl_fall) begin
                if (q.bit_n == 4'd8) begin
                  d.sda_oe = 1'b0;  // see R16
                  d.st     = dpot_pkg::DPOT_TXACK;
                end else begin
                  d.sda_oe = ~q.shift[3'(7 - q.bit_n)];
                  d.bit_n  = q.bit_n + 4'd1;
                end
              end
            end
            dpot_pkg::DPOT_TXACK: begin
              if (scl_rise) begin
                if (q.s2.sda) begin
                  d.st = dpot_pkg::DPOT_IDLE;  // see R18
                end else begin
                  d.ack_go = 1'b1;
                end
              end else if (scl_fall && q.ack_go) begin
                d.ack_go = 1'b0;
                d.st     = dpot_pkg::DPOT_TX;
                d.shift  = rd_byte;
                d.sda_oe = ~rd_byte[7];  // see R21
                d.bit_n  = 4'd1;
              end
            end
            default: d.st = dpot_pkg::DPOT_IDLE;
          endcase
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      q         <= '0;
      q.st      <= dpot_pkg::DPOT_POWERUP;  // see R14
      q.wiper   <= dpot_pkg::WIPER_POWERUP;  // see R3
      q.init_nv <= dpot_pkg::INIT_SHIPPED;  // see R4
      q.access  <= dpot_pkg::ACCESS_RESET;  // see R7
      q.user_nv <= {dpot_pkg::USER_BYTES{dpot_pkg::USER_SHIPPED}};
      q.s1      <= '{scl: 1'b1, sda: 1'b1};
      q.s2      <= '{scl: 1'b1, sda: 1'b1};
      q.s3      <= '{scl: 1'b1, sda: 1'b1};
      q.wl1     <= 1'b1;
      q.wl2     <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign sda_out   = 1'b0;  // open drain: only ever pulls low
  assign sda_oe    = q.sda_oe;
  assign wiper_tap = q.wiper;  // see R1 R2
  assign nv_busy   = (q.st == dpot_pkg::DPOT_NVWRITE);

endmodule

/* File: tb/dpot_master.sv */
// Purpose: two-wire bus master model facing the slave
// Assumes: tasks entered at an mclk falling edge; sda has a pull-up
// Notes:   clock stands high between frames
module dpot_master (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic bit_io(input logic b, output logic r);
    #50 sda_pull = ~b;
    #50 scl = 1'b1;
    #90 r = sda;
    #10 scl = 1'b0;
  endtask
  task automatic start_c();
    #50 sda_pull = 1'b0;
    #50 scl = 1'b1;
    #100 sda_pull = 1'b1;
    #100 scl = 1'b0;
  endtask
  task automatic stop_c();
    #50 sda_pull = 1'b1;
    #50 scl = 1'b1;
    #100 sda_pull = 1'b0;
    #100;
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = (r === 1'b0);
  endtask
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule

/* File: tb/dpot_slave_bench.sv */
// Purpose: register-level test of the pot slave over its two-wire bus
// Assumes: shortened power-up and nv write counts
// Notes:   expectations follow the register map only
module dpot_slave_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] REV = 8'h3c;  // arbitrary value
  logic       mclk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       write_lock_n = 1'b1;
  logic       scl;
  logic       pull;
  logic       sda_out;
  logic       sda_oe;
  logic [7:0] wiper_tap;
  logic       nv_busy;
  logic       k;
  int         fail_count = 0;
  int         check_count = 0;
  wire        sda = ~pull & (sda_oe ? sda_out : 1'b1);
  always #12.5 mclk = ~mclk;
  dpot_master dpot_master_inst (.scl(scl), .sda_pull(pull), .sda(sda));
  dpot_slave #(.NV_WRITE_CYCLES(50), .POWERUP_CYCLES(8), .REVISION(REV)) dpot_slave_inst (.mclk(mclk),
    .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .write_lock_n(write_lock_n), .wiper_tap(wiper_tap), .nv_busy(nv_busy));
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic dack);
    dpot_master_inst.start_c();
    dpot_master_inst.put_byte(8'h50, k);
    chk({7'h0, k}, 8'h01);
    dpot_master_inst.put_byte(a, k);
    chk({7'h0, k}, 8'h01);
    dpot_master_inst.put_byte(d, k);
    chk({7'h0, k}, {7'h0, dack});
    dpot_master_inst.stop_c();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    dpot_master_inst.start_c();
    dpot_master_inst.put_byte(8'h50, k);
    dpot_master_inst.put_byte(a, k);
    dpot_master_inst.start_c();
    dpot_master_inst.put_byte(8'h51, k);
    chk({7'h0, k}, 8'h01);
    dpot_master_inst.get_byte(1'b1, d);
    dpot_master_inst.stop_c();
    chk(d, exp);
  endtask
  // two bytes: master acks the first, nacks the second
  task automatic rd2(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    dpot_master_inst.start_c();
    dpot_master_inst.put_byte(8'h50, k);
    dpot_master_inst.put_byte(a, k);
    dpot_master_inst.start_c();
    dpot_master_inst.put_byte(8'h51, k);
    chk({7'h0, k}, 8'h01);
    dpot_master_inst.get_byte(1'b0, d);
    chk(d, exp);
    dpot_master_inst.get_byte(1'b1, d);
    chk(d, exp);
    dpot_master_inst.stop_c();
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (nv_busy !== 1'b0 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 200) begin
      fail_count++;
      give_verdict();
    end
  endtask
  initial begin
    repeat (100000) @(negedge mclk);
    fail_count++;
    give_verdict();
  end
  initial begin
    repeat (20) @(negedge mclk);
    chk(wiper_tap, 8'h80);
    chk({7'h0, sda_oe}, 8'h00);
    sys_rst = 1'b0;
    repeat (20) @(negedge mclk);
    chk(wiper_tap, 8'h80);
    $display("test reset done");
    rd(8'h01, REV);
    rd(8'h08, 8'h00);
    wr(8'h01, 8'h77, 1'b1);
    wait_idle();
    rd(8'h01, REV);
    dpot_master_inst.start_c();
    dpot_master_inst.put_byte(8'h52, k);
    chk({7'h0, k}, 8'h00);
    dpot_master_inst.stop_c();
    $display("test decode done");
    wr(8'h00, 8'h37, 1'b1);
    chk(wiper_tap, 8'h37);
    repeat (2) @(negedge mclk);
    chk({7'h0, nv_busy}, 8'h01);
    dpot_master_inst.start_c();
    dpot_master_inst.put_byte(8'h50, k);
    chk({7'h0, k}, 8'h00);
    dpot_master_inst.stop_c();
    wait_idle();
    rd(8'h00, 8'h37);
    wr(8'h02, 8'ha6, 1'b1);
    wait_idle();
    rd(8'h02, 8'ha6);
    wr(8'h07, 8'h99, 1'b1);
    wait_idle();
    rd(8'h07, 8'h00);
    $display("test nonvolatile done");
    wr(8'h08, 8'hff, 1'b1);
    rd(8'h08, 8'h80);
    wr(8'h00, 8'hc5, 1'b1);
    chk(wiper_tap, 8'hc5);
    chk({7'h0, nv_busy}, 8'h00);
    rd2(8'h00, 8'hc5);
    wr(8'h03, 8'h4e, 1'b1);
    chk({7'h0, nv_busy}, 8'h00);
    write_lock_n = 1'b0;
    wr(8'h00, 8'h11, 1'b0);
    chk(wiper_tap, 8'hc5);
    write_lock_n = 1'b1;
    wr(8'h08, 8'h00, 1'b1);
    rd(8'h00, 8'h37);
    rd(8'h03, 8'h00);
    $display("test volatile done");
    write_lock_n = 1'b0;
    wr(8'h02, 8'h5b, 1'b0);
    repeat (2) @(negedge mclk);
    chk({7'h0, nv_busy}, 8'h00);
    write_lock_n = 1'b1;
    rd(8'h02, 8'ha6);
    $display("test lock done");
    give_verdict();
  end
endmodule

/* File: tb/dpot_slave_chk.sv */
// Purpose: port checks of the pot register slave
// Assumes: one mclk domain, asynchronous active-high reset
// Notes:   bound into the slave at the foot of this file
module dpot_slave_chk #(
  parameter int unsigned NV_WRITE_CYCLES = dpot_pkg::NV_WRITE_CYC,
  parameter int unsigned POWERUP_CYCLES  = dpot_pkg::POWERUP_CYC
) (
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       write_lock_n,
  input wire logic [7:0] wiper_tap,
  input wire logic       nv_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RDY = POWERUP_CYCLES + 8;
  logic [31:0] up_q;
  logic [31:0] busy_q;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      up_q   <= '0;
      busy_q <= '0;
    end else begin
      up_q   <= (up_q < RDY) ? up_q + 32'd1 : up_q;
      busy_q <= nv_busy ? busy_q + 32'd1 : '0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  chk_pin_open_drain: assert property (sda_out == 1'b0) else $error("sda_out driven high");
  chk_reset_values: assert property ($fell(sys_rst) |-> wiper_tap == 8'h80 && !sda_oe)
    else $error("bad state at reset release");
  chk_powerup_mute: assert property (up_q < RDY |-> !sda_oe) else $error("drive during power-up");
  chk_drive_after_fall: assert property ($changed(sda_oe) |-> !$past(scl_in, 2))
    else $error("sda drive changed outside clock low");
  chk_ack_stands: assert property ($rose(sda_oe) |=> sda_oe [*4]) else $error("ack too short");
  chk_busy_quiet: assert property (nv_busy |-> !sda_oe) else $error("drive during nv write");
  chk_busy_by_stop: assert property ($rose(nv_busy) |->
    $past(scl_in, 3) && $past(sda_in, 3) && !$past(sda_in, 4)) else $error("nv write not launched by stop");
  chk_busy_min_len: assert property ($rose(nv_busy) |=> nv_busy [*8]) else $error("nv write too short");
  chk_busy_bound: assert property (busy_q <= NV_WRITE_CYCLES + 2) else $error("nv write too long");
  chk_lock_keeps: assert property ((!write_lock_n) [*4] ##0 (up_q == RDY) |=> $stable(wiper_tap))
    else $error("wiper changed under write lock");
  cover property ($rose(nv_busy));
  cover property ($rose(sda_oe));
  cover property ($changed(wiper_tap));
endmodule

bind dpot_slave dpot_slave_chk #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES), .POWERUP_CYCLES(POWERUP_CYCLES))
  dpot_slave_chk_inst (.mclk(mclk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .write_lock_n(write_lock_n), .wiper_tap(wiper_tap), .nv_busy(nv_busy));
